// ==== src/mbi_device.sv ====
`timescale 1ns/1ps
module mbi_device
	import mbi_pkg::*;
(
	input  wire logic              clk_i,
	input  wire logic              rst_n_i,
	input  wire logic              ce_i,
	input  wire logic              dsp_cmd_we_i,
	input  wire logic              dsp_vec_we_i,
	input  wire logic [DATA_W-1:0] dsp_wdata_i,
	output logic                   busy_o,
	output logic [DATA_W-1:0]      control_o,
	mbi_link_if.device             link
);
	import mbi_pkg::*;

	logic              ack_s1, ack_s2, ack_s3;
	logic              ds_s1, ds_s2, cs_s1, cs_s2, rw_s1, rw_s2;
	logic              rd_s1, rd_s2, wr_s1, wr_s2, wr_s3;
	logic [ADDR_W-1:0] addr_s1, addr_s2;
	logic [DATA_W-1:0] data_s1, data_s2;
	logic              mailbox_busy_flag;
	logic [DATA_W-1:0] mailbox_command_reg;
	logic [DATA_W-1:0] mailbox_vector_reg;
	logic [DATA_W-1:0] host_port_control_reg;
	logic              ack_second;
	logic              sd_act, sd_act_d;
	logic              mode_sep, acc_act, acc_prev, acc_is_wr, acc_end;
	logic              ack_fall, ack_rise;

	// Two-stage sync of every pin from the host
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{ack_s1, ack_s2, ds_s1, ds_s2, cs_s1, cs_s2} <= 6'h3F;
			{rd_s1, rd_s2, wr_s1, wr_s2} <= 4'hF;
			{rw_s1, rw_s2} <= 2'h3;
			addr_s1 <= '0;
			addr_s2 <= '0;
			data_s1 <= '0;
			data_s2 <= '0;
		end else if (ce_i) begin
			ack_s1 <= link.interrupt_acknowledge_n;
			ack_s2 <= ack_s1;
			ds_s1 <= link.data_strobe_n;
			ds_s2 <= ds_s1;
			cs_s1 <= link.chip_select_n;
			cs_s2 <= cs_s1;
			rw_s1 <= link.rd_wr_n;
			rw_s2 <= rw_s1;
			rd_s1 <= link.read_strobe_n;
			rd_s2 <= rd_s1;
			wr_s1 <= link.write_strobe_n;
			wr_s2 <= wr_s1;
			addr_s1 <= link.addr;
			addr_s2 <= addr_s1;
			data_s1 <= link.host_data;
			data_s2 <= data_s1;
		end
	end

	// Edge history taken from the second stage only
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_s3 <= 1'b1;
			wr_s3 <= 1'b1;
			sd_act_d <= 1'b0;
			acc_prev <= 1'b0;
		end else if (ce_i) begin
			ack_s3 <= ack_s2;
			wr_s3 <= wr_s2;
			sd_act_d <= sd_act;
			acc_prev <= acc_act;
		end
	end

	assign mode_sep = host_port_control_reg[CTRL_MODE_BIT];
	assign sd_act   = !ds_s2 && !cs_s2;
	assign acc_act  = mode_sep ? (!wr_s2 && !cs_s2) : sd_act;
	// Write access ends at strobe release; data and address are still held then
	assign acc_is_wr = mode_sep ? 1'b1 : !rw_s2;
	assign acc_end  = acc_prev && !acc_act && (mode_sep || !rw_s2);
	assign ack_fall = ack_s3 && !ack_s2;
	assign ack_rise = !ack_s3 && ack_s2;

	// DSP side writes of command and vector
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mailbox_command_reg <= '0;
			mailbox_vector_reg <= VECTOR_RESET;
		end else if (ce_i) begin
			if (dsp_cmd_we_i) begin
				mailbox_command_reg <= dsp_wdata_i;
			end
			if (dsp_vec_we_i) begin
				mailbox_vector_reg <= dsp_wdata_i;
			end
		end
	end

	// Busy flag: set wins over a simultaneous host clear
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			mailbox_busy_flag <= 1'b0;
		end else if (ce_i) begin
			if (dsp_cmd_we_i) begin
				mailbox_busy_flag <= 1'b1;
			end else if (acc_end && addr_s2 == ADDR_BUSY) begin
				mailbox_busy_flag <= 1'b0;
			end
		end
	end

	// Host writes to the control register
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			host_port_control_reg <= CTRL_RESET;
		end else if (ce_i && acc_end && acc_is_wr && addr_s2 == ADDR_CONTROL) begin
			host_port_control_reg <= data_s2;
		end
	end

	// Request output; mask leaves the flag alone so it returns when unmasked
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			link.host_interrupt_request <= 1'b0;
		end else if (ce_i) begin
			link.host_interrupt_request <= mailbox_busy_flag &&
				!host_port_control_reg[CTRL_MASK_BIT];
		end
	end

	// Pulse counter for separate-strobe acknowledge pairs
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			ack_second <= 1'b0;
		end else if (ce_i && ack_rise && mode_sep) begin
			ack_second <= !ack_second;
		end
	end

	// Vector drive; released on acknowledge rise
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			link.dev_data_oe <= 1'b0;
			link.dev_data <= '0;
		end else if (ce_i) begin
			if (ack_rise) begin
				link.dev_data_oe <= 1'b0;
			end else if (ack_fall && (!mode_sep || ack_second)) begin
				link.dev_data_oe <= 1'b1;
				link.dev_data <= mailbox_vector_reg;
			end
		end
	end

	// Status seen by the DSP
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			busy_o <= 1'b0;
			control_o <= CTRL_RESET;
		end else if (ce_i) begin
			busy_o <= mailbox_busy_flag;
			control_o <= host_port_control_reg;
		end
	end
endmodule : mbi_device

// ==== src/mbi_host.sv ====
`timescale 1ns/1ps
module mbi_host
	import mbi_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_n_i,
	input  wire logic        ce_i,
	input  wire logic [3:0]  s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [3:0]  s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	output logic             irq_o,
	mbi_link_if.host         link
);
	import mbi_pkg::*;

	typedef enum logic [4:0] {
		H_IDLE  = 5'b00001,
		H_PULSE = 5'b00010,
		H_GAP   = 5'b00100,
		H_WRITE = 5'b01000,
		H_REL   = 5'b10000
	} mbi_hstate_t;

	mbi_hstate_t       state;
	logic [3:0]        cnt;
	logic              second, is_sep;
	logic              req_s1, req_s2, req_s3;
	logic              oe_s1, oe_s2;
	logic [DATA_W-1:0] vec_s1, vec_s2, vector;
	logic [ADDR_W-1:0] wr_addr;
	logic [DATA_W-1:0] wr_data;
	logic              mode_sep;
	logic [1:0]        irq_stat, irq_mask;
	logic              done_ev;
	logic              aw_hold, w_hold;
	logic [3:0]        aw_addr;
	logic [31:0]       w_data;
	logic              wr_fire, busy;

	assign busy = (state != H_IDLE);
	assign wr_fire = aw_hold && w_hold && !s_axi_bvalid;

	// Synchronise device outputs
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			{req_s1, req_s2, req_s3, oe_s1, oe_s2} <= 5'h00;
			vec_s1 <= '0;
			vec_s2 <= '0;
		end else if (ce_i) begin
			req_s1 <= link.host_interrupt_request;
			req_s2 <= req_s1;
			req_s3 <= req_s2;
			oe_s1 <= link.dev_data_oe;
			oe_s2 <= oe_s1;
			vec_s1 <= link.dev_data;
			vec_s2 <= vec_s1;
		end
	end

	// AXI write channels taken in either order
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			aw_hold <= 1'b0;
			w_hold <= 1'b0;
			aw_addr <= 4'h0;
			w_data <= 32'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (ce_i) begin
			s_axi_awready <= !aw_hold && !s_axi_awready;
			s_axi_wready <= !w_hold && !s_axi_wready;
			if (s_axi_awvalid && s_axi_awready) begin
				aw_hold <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_hold <= 1'b1;
				w_data <= s_axi_wdata;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_addr == HOFF_CMD && busy) ? RESP_SLVERR : RESP_OKAY;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
				aw_hold <= 1'b0;
				w_hold <= 1'b0;
			end
		end
	end

	// Mask register write
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_mask <= 2'h0;
		end else if (ce_i && wr_fire && aw_addr == HOFF_MASK && s_axi_wstrb[0]) begin
			irq_mask <= w_data[1:0];
		end
	end

	// Sticky status; new event wins over write-one clear
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_stat <= 2'h0;
			irq_o <= 1'b0;
		end else if (ce_i) begin
			irq_stat <= (irq_stat & ~((wr_fire && aw_addr == HOFF_IRQ) ? w_data[1:0] : 2'h0))
				| {done_ev, req_s2 && !req_s3};
			irq_o <= |(irq_stat & irq_mask);
		end
	end

	// AXI read
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= RESP_OKAY;
		end else if (ce_i) begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= RESP_OKAY;
				unique case (s_axi_araddr)
					HOFF_CMD:    s_axi_rdata <= 32'h0;
					HOFF_STATUS: s_axi_rdata <= {16'h0, vector, 5'h0, mode_sep, req_s2, busy};
					HOFF_IRQ:    s_axi_rdata <= {30'h0, irq_stat};
					HOFF_MASK:   s_axi_rdata <= {30'h0, irq_mask};
					default: begin
						s_axi_rdata <= 32'h0;
						s_axi_rresp <= RESP_SLVERR;
					end
				endcase
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// Bus sequencer: acknowledge cycles and register writes
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= H_IDLE;
			cnt <= 4'h0;
			second <= 1'b0;
			is_sep <= 1'b0;
			done_ev <= 1'b0;
			vector <= VECTOR_RESET;
			mode_sep <= MODE_STROBE_DIR;
			wr_addr <= '0;
			wr_data <= '0;
			link.interrupt_acknowledge_n <= 1'b1;
			link.data_strobe_n <= 1'b1;
			link.chip_select_n <= 1'b1;
			link.rd_wr_n <= 1'b1;
			link.read_strobe_n <= 1'b1;
			link.write_strobe_n <= 1'b1;
			link.addr <= '0;
			link.host_data <= '0;
			link.host_data_oe <= 1'b0;
		end else if (ce_i) begin
			done_ev <= 1'b0;
			// Synced drive lags the pulse, so the vector may land after ack rise
			if (oe_s2) begin
				vector <= vec_s2;
			end
			unique case (state)
				H_IDLE: begin
					if (wr_fire && aw_addr == HOFF_CMD) begin
						cnt <= HOLD_CNT;
						if (w_data[CMD_ACK_BIT]) begin
							link.interrupt_acknowledge_n <= 1'b0;
							second <= 1'b0;
							state <= H_PULSE;
						end else if (w_data[CMD_CLR_BIT] || w_data[CMD_CTL_BIT]) begin
							wr_addr <= w_data[CMD_CLR_BIT] ? ADDR_BUSY : ADDR_CONTROL;
							wr_data <= w_data[CMD_DATA_LSB +: DATA_W];
							if (w_data[CMD_CTL_BIT]) begin
								mode_sep <= w_data[CMD_DATA_LSB + CTRL_MODE_BIT];
							end
							is_sep <= mode_sep;
							state <= H_WRITE;
						end
					end
				end
				H_PULSE: begin
					cnt <= cnt - 4'h1;
					if (cnt == 4'h0) begin
						link.interrupt_acknowledge_n <= 1'b1;
						cnt <= GAP_CNT;
						if (mode_sep && !second) begin
							second <= 1'b1; // Second pulse follows
							state <= H_GAP;
						end else begin
							done_ev <= 1'b1;
							state <= H_REL;
						end
					end
				end
				H_GAP: begin
					cnt <= cnt - 4'h1;
					if (cnt == 4'h0) begin
						link.interrupt_acknowledge_n <= 1'b0;
						cnt <= HOLD_CNT;
						state <= H_PULSE;
					end
				end
				H_WRITE: begin
					// Address, data, select first; strobe a cycle later
					link.addr <= wr_addr;
					link.host_data <= wr_data;
					link.host_data_oe <= 1'b1;
					link.chip_select_n <= 1'b0;
					link.rd_wr_n <= 1'b0;
					cnt <= cnt - 4'h1;
					if (cnt == HOLD_CNT - 4'h1) begin
						if (is_sep) link.write_strobe_n <= 1'b0;
						else link.data_strobe_n <= 1'b0;
					end
					if (cnt == 4'h0) begin
						link.write_strobe_n <= 1'b1;
						link.data_strobe_n <= 1'b1;
						cnt <= GAP_CNT;
						state <= H_REL;
					end
				end
				H_REL: begin
					// Hold address and data past strobe release
					cnt <= cnt - 4'h1;
					if (cnt == 4'h0) begin
						link.chip_select_n <= 1'b1;
						link.rd_wr_n <= 1'b1;
						link.host_data_oe <= 1'b0;
						if (link.host_data_oe) done_ev <= 1'b1;
						state <= H_IDLE;
					end
				end
			endcase
		end
	end
endmodule : mbi_host

// ==== src/mbi_link_if.sv ====
`timescale 1ns/1ps
interface mbi_link_if;
	import mbi_pkg::*;
	logic                host_interrupt_request;
	logic                interrupt_acknowledge_n;
	logic                data_strobe_n;
	logic                chip_select_n;
	logic                rd_wr_n;
	logic                read_strobe_n;
	logic                write_strobe_n;
	logic [ADDR_W-1:0]   addr;
	logic [DATA_W-1:0]   host_data;
	logic                host_data_oe;
	logic [DATA_W-1:0]   dev_data;
	logic                dev_data_oe;
	modport device (
		output host_interrupt_request,
		input  interrupt_acknowledge_n,
		input  data_strobe_n,
		input  chip_select_n,
		input  rd_wr_n,
		input  read_strobe_n,
		input  write_strobe_n,
		input  addr,
		input  host_data,
		input  host_data_oe,
		output dev_data,
		output dev_data_oe
	);
	modport host (
		input  host_interrupt_request,
		output interrupt_acknowledge_n,
		output data_strobe_n,
		output chip_select_n,
		output rd_wr_n,
		output read_strobe_n,
		output write_strobe_n,
		output addr,
		output host_data,
		output host_data_oe,
		input  dev_data,
		input  dev_data_oe
	);
endinterface : mbi_link_if

// ==== src/mbi_pkg.sv ====
package mbi_pkg;
	// Data bus width of the host port
	localparam int DATA_W = 8;
	// Bus mode select values
	localparam logic MODE_STROBE_DIR = 1'b0;
	localparam logic MODE_SEP_STROBE = 1'b1;
	// Address map of the host port, word index on the address pins
	localparam int ADDR_W = 2;
	localparam logic [ADDR_W-1:0] ADDR_BUSY    = 2'h0;
	localparam logic [ADDR_W-1:0] ADDR_CONTROL = 2'h1;
	// Control register field positions
	localparam int CTRL_MASK_BIT = 0;
	localparam int CTRL_MODE_BIT = 1;
	localparam logic [DATA_W-1:0] CTRL_RESET = 8'h00;
	localparam logic [DATA_W-1:0] VECTOR_RESET = 8'h00;
	// Minimum acknowledge pulse width and gap, ns
	localparam int ACK_PULSE_NS = 25;
	localparam int ACK_GAP_NS = 10;
	localparam int CLK_PERIOD_NS = 50;
	localparam int ACK_PULSE_CYC = (ACK_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ACK_GAP_CYC = (ACK_GAP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Host sequencer hold counts
	localparam int HOLD_CYC = ACK_PULSE_CYC + 3;
	localparam int GAP_CYC = ACK_GAP_CYC + 3;
	localparam logic [3:0] HOLD_CNT = 4'(HOLD_CYC);
	localparam logic [3:0] GAP_CNT = 4'(GAP_CYC);
	// Host AXI register offsets
	localparam logic [3:0] HOFF_CMD    = 4'h0;
	localparam logic [3:0] HOFF_STATUS = 4'h4;
	localparam logic [3:0] HOFF_IRQ    = 4'h8;
	localparam logic [3:0] HOFF_MASK   = 4'hC;
	// Command register fields
	localparam int CMD_GO_BIT = 0;
	localparam int CMD_ACK_BIT = 1;
	localparam int CMD_CLR_BIT = 2;
	localparam int CMD_CTL_BIT = 3;
	localparam int CMD_DATA_LSB = 8;
	// Interrupt status bits
	localparam int IRQ_REQ_BIT = 0;
	localparam int IRQ_DONE_BIT = 1;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage : mbi_pkg

// ==== verification/mbi_monitor.sv ====
`timescale 1ns/1ps
module mbi_monitor
	import mbi_pkg::*;
(
	input wire logic              clk_i,
	input wire logic              rst_n_i,
	input wire logic              host_interrupt_request,
	input wire logic              interrupt_acknowledge_n,
	input wire logic              data_strobe_n,
	input wire logic              chip_select_n,
	input wire logic              rd_wr_n,
	input wire logic              read_strobe_n,
	input wire logic              write_strobe_n,
	input wire logic [ADDR_W-1:0] addr,
	input wire logic [DATA_W-1:0] host_data,
	input wire logic              host_data_oe,
	input wire logic [DATA_W-1:0] dev_data,
	input wire logic              dev_data_oe
);
	logic [3:0] wr_age;
	logic [3:0] ack_age;
	logic       busy_wr;

	// Any host write counts: a control write may mask the request
	assign busy_wr = !chip_select_n
		&& ((!data_strobe_n && !rd_wr_n) || !write_strobe_n);

	// Cycles since the last host write, saturating
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) wr_age <= 4'hF;
		else if (busy_wr) wr_age <= 4'h0;
		else if (wr_age != 4'hF) wr_age <= wr_age + 4'h1;
	end

	// Cycles since acknowledge was last low, saturating
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) ack_age <= 4'hF;
		else if (!interrupt_acknowledge_n) ack_age <= 4'h0;
		else if (ack_age != 4'hF) ack_age <= ack_age + 4'h1;
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	a_req_write_only: assert property ($fell(host_interrupt_request) |-> wr_age < 4'hC)
		else $error("request dropped without a host write");
	a_req_ack_keep: assert property (($fell(interrupt_acknowledge_n) && host_interrupt_request
		&& wr_age == 4'hF) |=> host_interrupt_request [*4])
		else $error("request changed by acknowledge");
	a_vec_needs_ack: assert property (dev_data_oe |-> ack_age < 4'h5)
		else $error("vector driven without acknowledge");
	a_vec_after_hold: assert property ($rose(dev_data_oe) |-> !interrupt_acknowledge_n
		&& $past(!interrupt_acknowledge_n, 2))
		else $error("vector drive too early");
	a_vec_steady: assert property (dev_data_oe && $past(dev_data_oe) |-> $stable(dev_data))
		else $error("vector changed while driven");
	a_bus_no_clash: assert property (!(dev_data_oe && host_data_oe))
		else $error("both ends drive the data bus");
	a_bus_release: assert property ($rose(interrupt_acknowledge_n) |-> ##4 !dev_data_oe)
		else $error("bus not released after acknowledge");
	a_drive_ends: assert property (dev_data_oe && interrupt_acknowledge_n
		|-> ##[1:4] !dev_data_oe)
		else $error("vector drive outlasts acknowledge");

	cover property ($rose(dev_data_oe));
	cover property ($rose(host_interrupt_request));
	cover property ($fell(host_interrupt_request));
endmodule : mbi_monitor

// ==== verification/testbench.sv ====
`timescale 1ns/1ps
module testbench;
	import mbi_pkg::*;
	logic        clk_i = 1'b0;
	logic        rst_n_i = 1'b0;
	logic        cmd_we = 1'b0;
	logic        vec_we = 1'b0;
	logic [7:0]  dsp_wdata = 8'h00;
	logic        busy;
	logic [7:0]  control;
	logic        irq;
	logic [3:0]  awaddr = 4'h0;
	logic [3:0]  araddr = 4'h0;
	logic [31:0] wdata = 32'h0;
	logic [31:0] rdata;
	logic [1:0]  bresp;
	logic [1:0]  rresp;
	logic        awvalid = 1'b0;
	logic        wvalid = 1'b0;
	logic        bready = 1'b0;
	logic        arvalid = 1'b0;
	logic        rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	int          miscompares = 0;
	int          checks_done = 0;
	int          seed = 15;
	int          busy_m = 0;
	int          mask_m = 0;
	int          mode_m = 0;
	logic [7:0]  vec_q[$];
	logic [31:0] d;
	logic [1:0]  r;

	mbi_link_if link ();
	mbi_device u_mbi_device (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
		.dsp_cmd_we_i(cmd_we), .dsp_vec_we_i(vec_we), .dsp_wdata_i(dsp_wdata),
		.busy_o(busy), .control_o(control), .link(link));
	mbi_host u_mbi_host (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .irq_o(irq), .link(link));
	mbi_monitor u_mbi_monitor (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.host_interrupt_request(link.host_interrupt_request),
		.interrupt_acknowledge_n(link.interrupt_acknowledge_n),
		.data_strobe_n(link.data_strobe_n), .chip_select_n(link.chip_select_n),
		.rd_wr_n(link.rd_wr_n), .read_strobe_n(link.read_strobe_n),
		.write_strobe_n(link.write_strobe_n), .addr(link.addr), .host_data(link.host_data),
		.host_data_oe(link.host_data_oe), .dev_data(link.dev_data),
		.dev_data_oe(link.dev_data_oe));

	// Free-running 20 MHz clock
	always #25 clk_i = ~clk_i;

	task automatic complete_run();
		$display("checks %0d mismatches %0d", checks_done, miscompares);
		if (miscompares == 0 && checks_done > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : complete_run

	task automatic cmp(input string name, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			miscompares++;
			$display("unexpected %s expected %h seen %h", name, e, g);
		end
	endtask : cmp

	// Address and data offered together, each dropped once taken
	task automatic wr(input logic [3:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge clk_i);
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid);
		bready <= 1'b0;
		cmp("bresp", 32'(er), 32'(bresp));
	endtask : wr

	task automatic rd(input logic [3:0] a);
		@(posedge clk_i);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge clk_i);
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
	endtask : rd

	// Poll until the sequencer is idle, then let the pins settle
	task automatic seq_wait();
		for (int i = 0; i < 100; i++) begin
			rd(HOFF_STATUS);
			if (d[0] === 1'b0) break;
		end
		repeat (5) @(posedge clk_i);
	endtask : seq_wait

	task automatic check_link();
		cmp("busy", 32'(busy_m), 32'(busy));
		cmp("request", 32'(busy_m && !mask_m), 32'(link.host_interrupt_request));
		rd(HOFF_STATUS);
		cmp("status", 32'(mode_m * 4 + (busy_m && !mask_m) * 2), 32'(d[2:0]));
	endtask : check_link

	task automatic set_ctrl(input int m, input int k);
		mode_m = m;
		mask_m = k;
		wr(HOFF_CMD, 32'(1 << CMD_CTL_BIT) | 32'((k + m * 2) << CMD_DATA_LSB), RESP_OKAY);
		seq_wait();
		cmp("control", 32'(k + m * 2), 32'(control));
	endtask : set_ctrl

	// Interrupt output is registered from status, so let it settle first
	task automatic chk_irq(input logic e);
		repeat (2) @(posedge clk_i);
		cmp("irq", 32'(e), 32'(irq));
	endtask : chk_irq

	task automatic dsp(input logic vw, input logic cw, input logic [7:0] v);
		@(posedge clk_i);
		vec_we <= vw;
		cmd_we <= cw;
		dsp_wdata <= v;
		@(posedge clk_i);
		vec_we <= 1'b0;
		cmd_we <= 1'b0;
	endtask : dsp

	initial begin
		repeat (4) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (2) @(posedge clk_i);
		cmp("control", 32'(CTRL_RESET), 32'(control));
		check_link();
		for (int m = 0; m < 2; m++) begin
			set_ctrl(m, 0);
			wr(HOFF_MASK, 32'h1, RESP_OKAY);
			wr(HOFF_IRQ, 32'h3, RESP_OKAY);
			chk_irq(1'b0);
			vec_q.push_back(8'($random(seed)));
			dsp(1'b1, 1'b0, vec_q[0]);
			dsp(1'b0, 1'b1, 8'($random(seed)));
			busy_m = 1;
			repeat (6) @(posedge clk_i);
			check_link();
			chk_irq(1'b1);
			wr(HOFF_IRQ, 32'h1, RESP_OKAY);
			chk_irq(1'b0);
			set_ctrl(m, 1);
			check_link();
			set_ctrl(m, 0);
			check_link();
			chk_irq(1'b1);
			wr(HOFF_MASK, 32'h0, RESP_OKAY);
			chk_irq(1'b0);
			wr(HOFF_CMD, 32'(1 << CMD_ACK_BIT), RESP_OKAY);
			wr(HOFF_CMD, 32'(1 << CMD_ACK_BIT), RESP_SLVERR);
			seq_wait();
			rd(HOFF_STATUS);
			cmp("vector", 32'(vec_q.pop_front()), 32'(d[15:8]));
			check_link();
			wr(HOFF_CMD, 32'(1 << CMD_CLR_BIT), RESP_OKAY);
			seq_wait();
			busy_m = 0;
			check_link();
		end
		rd(4'h2);
		cmp("rresp", 32'(RESP_SLVERR), 32'(r));
		complete_run();
	end

	// Whole run needs well under 20000 cycles
	initial begin
		#1000000;
		miscompares++;
		complete_run();
	end
endmodule : testbench
